// >>> verilog/stpb_pkg.sv
// package: constants and encodings of the serial to pin and 2-wire bridge
package stpb_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ    = 250_000_000;
  localparam int SYS_PERIOD_NS = 4;
  localparam int BAUD_BPS      = 57600;
  localparam int BIT_CYC_DEF   = SYS_CLK_HZ / BAUD_BPS;
  localparam int BIT_CNT_W     = 13;
  localparam int TWI_QTR_NS    = 2500;
  localparam int TWI_QTR_CYC   = (TWI_QTR_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int TWI_CNT_W     = 10;
  localparam int HB_SLOW_MS    = 250;
  localparam int HB_SLOW_DEF   = HB_SLOW_MS * (SYS_CLK_HZ / 1000);
  localparam int HB_FAST_SHIFT = 3;
  // ----------------------------------------------------------------
  // pins: index 0..10 is pin 1..11
  // ----------------------------------------------------------------
  localparam int NUM_PINS = 11;
  localparam int PIN_HB   = 2;
  localparam int PIN_SCL  = 9;
  localparam int PIN_SDA  = 10;
  // ----------------------------------------------------------------
  // serial commands and answers
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_TWI_START = 8'hA0;
  localparam logic [7:0] CMD_TWI_WRITE = 8'hA1;
  localparam logic [7:0] CMD_TWI_READ  = 8'hA2;
  localparam logic [7:0] CMD_TWI_STOP  = 8'hA3;
  localparam logic [7:0] CMD_TWI_TOG9  = 8'hA4;
  localparam logic [7:0] CMD_REV       = 8'hC2;
  localparam logic [7:0] CMD_PIN_WR    = 8'hE1;
  localparam logic [7:0] CMD_PIN_RD    = 8'hE2;
  localparam logic [7:0] CMD_PIN_REL   = 8'hE3;
  localparam logic [7:0] CMD_HB        = 8'hE4;
  localparam logic [7:0] ACK_XOR       = 8'h10;
  localparam logic [7:0] ERR_CODE      = 8'hFA;
  localparam int         BANNER_LEN    = 9;
  // ----------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DIV  = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_PINS = 8'h0C;
  localparam int CTRL_HB_EN   = 0;
  localparam int CTRL_HB_FAST = 1;
  localparam logic [2:0] AHB_SIZE_WORD = 3'h2;
  localparam logic [1:0] AHB_RESP_OKAY = 2'h0;
  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_BANNER, ST_CMD1, ST_CMD2, ST_EXEC, ST_TWI, ST_REPLY}
    stpb_state_type;
  typedef enum logic [2:0] {OP_START, OP_WRITE, OP_READ, OP_STOP, OP_TOG9} stpb_op_type;
endpackage

// >>> verilog/stpb_uart.sv
// serial link: 8N1 receiver and transmitter, lsb first
`timescale 1ns/1ps
module stpb_uart
  import stpb_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYC_DEF
) (
  input  wire logic       sysClk,   // system clock
  input  wire logic       rstn,     // synchronised reset, active low
  input  wire logic       clr,      // hold idle
  input  wire logic       rxd,      // serial in
  output logic            txd,      // serial out
  output logic [7:0]      rxByte,   // received byte
  output logic            rxValid,  // one-cycle pulse with rxByte
  input  wire logic [7:0] txByte,   // byte to send
  input  wire logic       txValid,  // send request
  output logic            txReady   // transmitter idle
);
  typedef struct packed {
    logic [BIT_CNT_W-1:0] rxCnt;
    logic [3:0]           rxBit;
    logic                 rxBusy;
    logic [7:0]           rxSh;
    logic [7:0]           rxByte;
    logic                 rxValid;
    logic [BIT_CNT_W-1:0] txCnt;
    logic [3:0]           txBit;
    logic                 txBusy;
    logic [8:0]           txSh;
    logic                 txd;
  } stpb_uart_type;

  stpb_uart_type q, d;

  always_comb begin
    d = q;
    d.rxValid = 1'b0;
    // ----------------------------------------------------------------
    // receive, sampled mid-bit
    // ----------------------------------------------------------------
    if (!q.rxBusy) begin
      if (!rxd) begin
        d.rxBusy = 1'b1;
        d.rxBit  = 4'h0;
        d.rxCnt  = BIT_CNT_W'(BIT_CYC / 2);
      end
    end else if (q.rxCnt != '0) begin
      d.rxCnt = q.rxCnt - 1'b1;
    end else begin
      d.rxCnt = BIT_CNT_W'(BIT_CYC - 1);
      d.rxBit = q.rxBit + 1'b1;
      if (q.rxBit == 4'h0) begin
        // a glitch is not a start bit
        d.rxBusy = !rxd;
      end else if (q.rxBit == 4'h9) begin
        d.rxBusy = 1'b0;
        if (rxd) begin
          d.rxValid = 1'b1;
          d.rxByte  = q.rxSh;
        end
      end else begin
        d.rxSh = {rxd, q.rxSh[7:1]};
      end
    end
    // ----------------------------------------------------------------
    // transmit
    // ----------------------------------------------------------------
    if (!q.txBusy) begin
      if (txValid) begin
        d.txBusy = 1'b1;
        d.txSh   = {1'b1, txByte};
        d.txd    = 1'b0;
        d.txBit  = 4'h0;
        d.txCnt  = BIT_CNT_W'(BIT_CYC - 1);
      end
    end else if (q.txCnt != '0) begin
      d.txCnt = q.txCnt - 1'b1;
    end else if (q.txBit == 4'h9) begin
      d.txBusy = 1'b0;
      d.txd    = 1'b1;
    end else begin
      d.txd   = q.txSh[0];
      d.txSh  = {1'b0, q.txSh[8:1]};
      d.txBit = q.txBit + 1'b1;
      d.txCnt = BIT_CNT_W'(BIT_CYC - 1);
    end
    if (clr) begin
      d        = '0;
      d.txd    = 1'b1;
    end
  end

  always_ff @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      q     <= '0;
      q.txd <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign txd     = q.txd;
  assign rxByte  = q.rxByte;
  assign rxValid = q.rxValid;
  assign txReady = !q.txBusy;
endmodule

// >>> verilog/stpb_bridge.sv
// top: serial command interpreter driving 2-wire bus and eleven i/o pins
`timescale 1ns/1ps
module stpb_bridge
  import stpb_pkg::*;
#(
  parameter int          BIT_CYC   = BIT_CYC_DEF,
  parameter int          HB_SLOW   = HB_SLOW_DEF,
  // banner text and revision values are arbitrary
  parameter logic [71:0] BANNER    = 72'h42_5244_4720_7231_2E30,
  parameter logic [7:0]  REV_MAJOR = 8'h01,
  parameter logic [7:0]  REV_MINOR = 8'h00
) (
  input  wire logic                sysClk,     // 250 MHz system clock
  input  wire logic                resetn,     // async reset, active low
  input  wire logic                dtrOn,      // host DTR, high when ON
  input  wire logic                rxd,        // serial data from host
  output logic                     txd,        // serial data to host
  input  wire logic [NUM_PINS-1:0] ioIn,       // pin levels
  output logic [NUM_PINS-1:0]      ioOut,      // pin output values
  output logic [NUM_PINS-1:0]      ioOe,       // pin drive enables
  input  wire logic                hsel,       // ahb slave select
  input  wire logic [31:0]         haddr,      // ahb address
  input  wire logic [1:0]          htrans,     // ahb transfer type
  input  wire logic                hwrite,     // ahb write
  input  wire logic [2:0]          hsize,      // ahb size
  input  wire logic [31:0]         hwdata,     // ahb write data
  input  wire logic                hready,     // ahb bus ready
  output logic                     hreadyout,  // ahb slave ready
  output logic [1:0]               hresp,      // ahb response
  output logic [31:0]              hrdata      // ahb read data
);
  typedef struct packed {
    stpb_state_type        st;
    logic [3:0]            banIdx;
    logic [7:0]            cmd;
    logic [7:0]            arg;
    logic [2:0][7:0]       rep;
    logic [1:0]            repCnt;
    logic [1:0]            repIdx;
    logic                  txValid;
    logic [7:0]            txByte;
    stpb_op_type           op;
    logic [1:0]            ph;
    logic [3:0]            bitNo;
    logic [TWI_CNT_W-1:0]  tick;
    logic [7:0]            sh;
    logic                  gotAck;
    logic                  sclLow;
    logic                  sdaLow;
    logic                  twiMode;
    logic [NUM_PINS-1:0]   pinOut;
    logic [NUM_PINS-1:0]   pinOe;
    logic                  hbEn;
    logic                  hbFast;
    logic [31:0]           hbDiv;
    logic [31:0]           hbCnt;
    logic                  hbLvl;
    logic [NUM_PINS-1:0]   padOut;
    logic [NUM_PINS-1:0]   padOe;
    logic                  ahbSel;
    logic                  ahbWr;
    logic [7:0]            ahbAddr;
    logic [31:0]           rdata;
  } stpb_core_type;

  stpb_core_type q, d;
  logic [1:0]    rstSync;
  logic          rstn;
  logic [7:0]    rxByte;
  logic          rxValid;
  logic          txReady;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  always_ff @(posedge sysClk or negedge resetn) begin
    if (!resetn) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstn = rstSync[1];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic pinOk(input logic [7:0] a);
    return a[7:4] < 4'(NUM_PINS);
  endfunction

  function automatic logic [7:0] bannerByte(input logic [3:0] i);
    logic [71:0] s;
    s = BANNER << (8 * i);
    return s[71:64];
  endfunction

  function automatic logic [31:0] regRead(input logic [7:0] a, input stpb_core_type c);
    logic [31:0] r;
    r = '0;
    case (a)
      REG_CTRL: begin
        r[CTRL_HB_EN]   = c.hbEn;
        r[CTRL_HB_FAST] = c.hbFast;
      end
      REG_DIV:  r = c.hbDiv;
      REG_STAT: r = {27'h000_0000, c.twiMode, 1'b0, c.st};
      REG_PINS: r = {5'h00, c.padOe, 5'h00, ioIn};
      default:  r = '0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // serial link
  // ----------------------------------------------------------------
  stpb_uart #(.BIT_CYC(BIT_CYC)) uLink (
    .sysClk  (sysClk),
    .rstn    (rstn),
    .clr     (!dtrOn),
    .rxd     (rxd),
    .txd     (txd),
    .rxByte  (rxByte),
    .rxValid (rxValid),
    .txByte  (q.txByte),
    .txValid (q.txValid),
    .txReady (txReady)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] lim;
    logic        sdaIn;
    logic [3:0]  p;
    lim   = q.hbFast ? (q.hbDiv >> HB_FAST_SHIFT) : q.hbDiv;
    d     = q;
    sdaIn = ioIn[PIN_SDA];
    p     = q.arg[7:4];
    if (q.txValid && txReady) begin
      d.txValid = 1'b0;
    end

    // heartbeat divider
    if (q.hbCnt + 32'h0000_0001 >= lim) begin
      d.hbCnt = '0;
      d.hbLvl = !q.hbLvl;
    end else begin
      d.hbCnt = q.hbCnt + 32'h0000_0001;
    end

    case (q.st)
      ST_BANNER: begin
        if (!q.txValid) begin
          if (q.banIdx == 4'(BANNER_LEN)) begin
            d.st = ST_CMD1;
          end else begin
            d.txByte  = bannerByte(q.banIdx);
            d.txValid = 1'b1;
            d.banIdx  = q.banIdx + 1'b1;
          end
        end
      end
      ST_CMD1: begin
        if (rxValid) begin
          d.cmd = rxByte;
          d.st  = ST_CMD2;
        end
      end
      ST_CMD2: begin
        if (rxValid) begin
          d.arg = rxByte;
          d.st  = ST_EXEC;
        end
      end
      ST_EXEC: begin
        d.st     = ST_REPLY;
        d.repIdx = 2'h0;
        d.repCnt = 2'h1;
        d.rep[0] = q.cmd ^ ACK_XOR;
        d.ph     = 2'h0;
        d.bitNo  = 4'h0;
        d.tick   = TWI_CNT_W'(TWI_QTR_CYC - 1);
        d.sh     = q.arg;
        case (q.cmd)
          CMD_TWI_START, CMD_TWI_WRITE, CMD_TWI_READ, CMD_TWI_STOP,
          CMD_TWI_TOG9: begin
            d.st      = ST_TWI;
            d.twiMode = 1'b1;
            case (q.cmd)
              CMD_TWI_START: d.op = OP_START;
              CMD_TWI_WRITE: d.op = OP_WRITE;
              CMD_TWI_READ:  d.op = OP_READ;
              CMD_TWI_STOP:  d.op = OP_STOP;
              default:       d.op = OP_TOG9;
            endcase
          end
          CMD_REV: begin
            d.rep    = {q.cmd ^ ACK_XOR, REV_MINOR, REV_MAJOR};
            d.repCnt = 2'h3;
          end
          CMD_PIN_WR: begin
            if (pinOk(q.arg)) begin
              d.pinOut[p] = q.arg[0];
              d.pinOe[p]  = 1'b1;
              if (p == 4'(PIN_SCL) || p == 4'(PIN_SDA)) begin
                d.twiMode = 1'b0;
              end
            end else begin
              d.rep[0] = ERR_CODE;
            end
          end
          CMD_PIN_RD: begin
            if (pinOk(q.arg)) begin
              d.rep    = {8'h00, q.cmd ^ ACK_XOR, 7'h00, ioIn[p]};
              d.repCnt = 2'h2;
            end else begin
              d.rep[0] = ERR_CODE;
            end
          end
          CMD_PIN_REL: begin
            if (pinOk(q.arg)) begin
              d.pinOe[p] = 1'b0;
            end else begin
              d.rep[0] = ERR_CODE;
            end
          end
          CMD_HB: begin
            d.hbEn   = q.arg[CTRL_HB_EN];
            d.hbFast = q.arg[CTRL_HB_FAST];
          end
          default: d.rep[0] = ERR_CODE;
        endcase
      end
      ST_TWI: begin
        if (q.tick != '0) begin
          d.tick = q.tick - 1'b1;
        end else begin
          d.tick = TWI_CNT_W'(TWI_QTR_CYC - 1);
          d.ph   = q.ph + 1'b1;
          case (q.op)
            OP_START: begin
              case (q.ph)
                2'h0:    d.sdaLow = 1'b0;
                2'h1:    d.sclLow = 1'b0;
                2'h2:    d.sdaLow = 1'b1;
                default: begin
                  d.sclLow = 1'b1;
                  d.st     = ST_REPLY;
                end
              endcase
            end
            OP_STOP: begin
              case (q.ph)
                2'h0:    d.sdaLow = 1'b1;
                2'h1:    d.sclLow = 1'b0;
                default: begin
                  d.sdaLow = 1'b0;
                  d.st     = ST_REPLY;
                end
              endcase
            end
            default: begin
              case (q.ph)
                2'h0: begin
                  if (q.op == OP_WRITE) begin
                    d.sdaLow = (q.bitNo != 4'h8) && !q.sh[7];
                  end else if (q.op == OP_READ) begin
                    d.sdaLow = (q.bitNo == 4'h8) && q.arg[0];
                  end else begin
                    d.sdaLow = 1'b0;
                  end
                end
                2'h1:    d.sclLow = 1'b0;
                2'h2: begin
                  if (q.bitNo != 4'h8) begin
                    d.sh = {q.sh[6:0], sdaIn};
                  end
                  d.gotAck = !sdaIn;
                end
                default: begin
                  d.sclLow = 1'b1;
                  d.bitNo  = q.bitNo + 1'b1;
                  if (q.bitNo == 4'h8) begin
                    d.sdaLow = 1'b0;
                    d.st     = ST_REPLY;
                    if (q.op == OP_READ) begin
                      d.rep    = {8'h00, q.cmd ^ ACK_XOR, q.sh};
                      d.repCnt = 2'h2;
                    end else if (q.op == OP_WRITE && !q.gotAck) begin
                      d.rep[0] = ERR_CODE;
                    end
                  end
                end
              endcase
            end
          endcase
        end
      end
      ST_REPLY: begin
        if (!q.txValid) begin
          if (q.repIdx == q.repCnt) begin
            d.st = ST_CMD1;
          end else begin
            d.txByte  = q.rep[q.repIdx];
            d.txValid = 1'b1;
            d.repIdx  = q.repIdx + 1'b1;
          end
        end
      end
      default: d.st = ST_CMD1;
    endcase

    // ----------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // ----------------------------------------------------------------
    if (q.ahbSel && q.ahbWr) begin
      case (q.ahbAddr)
        REG_CTRL: begin
          d.hbEn   = hwdata[CTRL_HB_EN];
          d.hbFast = hwdata[CTRL_HB_FAST];
        end
        REG_DIV:  d.hbDiv = hwdata;
        default:  d.hbDiv = d.hbDiv;
      endcase
    end
    d.ahbSel  = hsel && hready && htrans[1] && hsize == AHB_SIZE_WORD;
    d.ahbWr   = hwrite;
    d.ahbAddr = haddr[7:0];
    d.rdata   = (hsel && hready && htrans[1] && !hwrite) ? regRead(haddr[7:0], q) : '0;

    // dtr off holds state, pin enables, 2-wire drive and heartbeat control at start-up values
    if (!dtrOn) begin
      d.st      = ST_BANNER;
      d.banIdx  = 4'h0;
      d.txValid = 1'b0;
      d.pinOe   = '0;
      d.twiMode = 1'b0;
      d.sclLow  = 1'b0;
      d.sdaLow  = 1'b0;
      d.hbEn    = 1'b1;
      d.hbFast  = 1'b0;
      d.hbCnt   = '0;
      d.hbLvl   = 1'b0;
    end

    // pad drive, registered
    for (int i = 0; i < NUM_PINS; i++) begin
      if (i == PIN_HB) begin
        d.padOut[i] = 1'b0;
        d.padOe[i]  = d.hbEn ? !d.hbLvl : (d.pinOe[i] && !d.pinOut[i]);
      end else if ((i == PIN_SCL || i == PIN_SDA) && d.twiMode) begin
        d.padOut[i] = 1'b0;
        d.padOe[i]  = (i == PIN_SCL) ? d.sclLow : d.sdaLow;
      end else begin
        d.padOut[i] = d.pinOut[i];
        d.padOe[i]  = d.pinOe[i];
      end
    end
  end

  always_ff @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      q       <= '0;
      q.hbEn  <= 1'b1;
      q.hbDiv <= HB_SLOW;
    end else begin
      q <= d;
    end
  end

  assign ioOut     = q.padOut;
  assign ioOe      = q.padOe;
  assign hreadyout = 1'b1;
  assign hresp     = AHB_RESP_OKAY;
  assign hrdata    = q.rdata;
endmodule

// >>> bench/stpb_bridge_checker.sv
// checker: port-level assertions of the bridge top
`timescale 1ns/1ps
module stpb_bridge_checker
  import stpb_pkg::*;
(
  input wire logic                sysClk,     // system clock
  input wire logic                resetn,     // async reset, active low
  input wire logic                dtrOn,      // host DTR
  input wire logic                txd,        // serial out
  input wire logic [NUM_PINS-1:0] ioOut,      // pin values
  input wire logic [NUM_PINS-1:0] ioOe,       // pin enables
  input wire logic                hsel,       // ahb select
  input wire logic [1:0]          htrans,     // ahb transfer type
  input wire logic                hwrite,     // ahb write
  input wire logic                hready,     // ahb ready
  input wire logic                hreadyout,  // ahb slave ready
  input wire logic [1:0]          hresp,      // ahb response
  input wire logic [31:0]         hrdata      // ahb read data
);
  default clocking dc @(posedge sysClk); endclocking
  default disable iff (!resetn);
  held_quiet_a: assert property (!dtrOn [*4] |-> txd)
    else $error("txd active while held");
  held_inputs_a: assert property (!dtrOn [*4] |-> (ioOe & 11'h7FB) == 11'h000)
    else $error("pin driver on while held");
  banner_start_a: assert property ($rose(dtrOn) |-> ##[1:8] !txd)
    else $error("no banner start after release");
  start_bit_a: assert property ($fell(txd) |-> !txd [*8])
    else $error("serial bit too short");
  hb_drain_a: assert property (ioOe[PIN_HB] |-> !ioOut[PIN_HB])
    else $error("heartbeat pin driven high");
  ready_high_a: assert property (hsel && htrans[1] |=> hreadyout)
    else $error("slave not ready");
  resp_okay_a: assert property (hresp == AHB_RESP_OKAY)
    else $error("response not okay");
  rdata_idle_a: assert property (!$past(hsel && hready && htrans[1] && !hwrite)
                                 |-> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");
  cover property ($rose(dtrOn));
  cover property (hsel && htrans[1] && !hwrite);
  cover property ($rose(ioOe[PIN_SCL]));
endmodule

bind stpb_bridge stpb_bridge_checker i_chk (.sysClk(sysClk), .resetn(resetn), .dtrOn(dtrOn),
  .txd(txd), .ioOut(ioOut), .ioOe(ioOe), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

// >>> bench/stpb_host_model.sv
// host model: serial link partner and DTR control
`timescale 1ns/1ps
module stpb_host_model
  import stpb_pkg::*;
#(
  parameter int BIT_CYC = 16
) (
  input  wire logic sysClk,  // system clock
  input  wire logic txd,     // serial data from the block
  output logic      rxd,     // serial data to the block
  output logic      dtrOn    // DTR, high when on
);
  initial begin
    rxd   = 1'b1;
    dtrOn = 1'b0;
  end
  task automatic set_dtr(input logic on);
    @(posedge sysClk);
    dtrOn <= on;
  endtask
  // full stop bit: the receiver checks it mid-bit, before the next start may follow
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sysClk);
      rxd <= frame[i];
      repeat (BIT_CYC - 1) @(posedge sysClk);
    end
  endtask
  task automatic send(input logic [7:0] c, input logic [7:0] a);
    send_byte(c);
    send_byte(a);
  endtask
  task automatic get_byte(output logic [7:0] b);
    do @(posedge sysClk); while (txd !== 1'b0);
    repeat (BIT_CYC / 2) @(posedge sysClk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge sysClk);
      b[i] = txd;
    end
    repeat (BIT_CYC) @(posedge sysClk);
  endtask
endmodule

// >>> bench/stpb_bridge_bench.sv
// testbench: host commands, pin levels and register accesses
`timescale 1ns/1ps
module stpb_bridge_bench;
  import stpb_pkg::*;
  localparam int          BC  = 16;
  localparam int          HS  = 64;
  localparam logic [71:0] BAN = 72'h42_5244_4720_7231_2E30;
  logic sysClk = 1'b0;
  logic resetn, dtrOn, rxd, txd, hsel, hwrite, hreadyout, hbPrev;
  logic [NUM_PINS-1:0] ioIn, ioOut, ioOe;
  logic [NUM_PINS-1:0] extLvl = 11'h6A5;
  logic [31:0]         haddr, hwdata, hrdata;
  logic [1:0]          htrans, hresp;
  logic [2:0]          hsize;
  int                  n_mismatch, tests_run, hbCnt;
  // ----------------------------------------------------------------
  // clock, pins, instances
  // ----------------------------------------------------------------
  always #2 sysClk = ~sysClk;
  // pulled-up or external level wherever the block is not driving
  assign ioIn = (ioOe & ioOut) | (~ioOe & extLvl);
  always @(posedge sysClk) begin
    hbPrev <= ioOe[PIN_HB];
    if (ioOe[PIN_HB] !== hbPrev) hbCnt <= hbCnt + 1;
  end
  stpb_host_model #(.BIT_CYC(BC)) i_host (.sysClk(sysClk), .txd(txd), .rxd(rxd), .dtrOn(dtrOn));
  stpb_bridge #(.BIT_CYC(BC), .HB_SLOW(HS), .BANNER(BAN)) i_dut (.sysClk(sysClk),
    .resetn(resetn), .dtrOn(dtrOn), .rxd(rxd), .txd(txd), .ioIn(ioIn), .ioOut(ioOut),
    .ioOe(ioOe), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, wd, output logic [31:0] rd);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'b10; hsize <= AHB_SIZE_WORD;
    do @(posedge sysClk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    do @(posedge sysClk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic reply(input logic [7:0] e);
    logic [7:0] b;
    i_host.get_byte(b);
    chk("reply", {24'h0, e}, {24'h0, b});
  endtask
  task automatic banner();
    logic [7:0] b;
    for (int i = 0; i < BANNER_LEN; i++) begin
      i_host.get_byte(b);
      chk("banner", {24'h0, BAN[71-8*i -: 8]}, {24'h0, b});
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge sysClk);
    n_mismatch++;
    close_out();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    resetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
    hsize = AHB_SIZE_WORD; hwdata = '0; hbCnt = 0; n_mismatch = 0; tests_run = 0;
    repeat (5) @(posedge sysClk);
    resetn <= 1'b1;
    repeat (20) @(posedge sysClk);
    chk("oeHeld", 32'h0, {21'h0, ioOe & 11'h7FB});
    chk("txdHeld", 32'h1, {31'h0, txd});
    ahb(1'b0, {24'h0, REG_CTRL}, 32'h0, rd); chk("ctrl", 32'h0000_0001, rd);
    ahb(1'b0, {24'h0, REG_DIV}, 32'h0, rd); chk("div", HS, rd);
    ahb(1'b1, {24'h0, REG_DIV}, 32'h0000_0020, rd);
    ahb(1'b0, {24'h0, REG_DIV}, 32'h0, rd); chk("div", 32'h0000_0020, rd);
    ahb(1'b1, 32'h0000_0040, 32'hFFFF_FFFF, rd);
    ahb(1'b0, 32'h0000_0040, 32'h0, rd); chk("unmapped", 32'h0, rd);
    ahb(1'b0, {24'h0, REG_PINS}, 32'h0, rd); chk("pins", 32'h0000_06A1, rd & 32'h07FB_07FB);
    hbCnt = 0;
    i_host.set_dtr(1'b1);
    banner();
    chk("hbRun", 32'h1, 32'(hbCnt != 0));
    i_host.send(CMD_REV, 8'h00);
    reply(8'h01); reply(8'h00); reply(8'hD2);
    i_host.send(8'h77, 8'h00); reply(ERR_CODE);
    i_host.send(CMD_PIN_RD, 8'hF0); reply(ERR_CODE);
    i_host.send(CMD_PIN_WR, 8'h01); reply(8'hF1);
    chk("pin0", 32'h3, {30'h0, ioOe[0], ioOut[0]});
    i_host.send(CMD_PIN_RD, 8'h10); reply(8'h00); reply(8'hF2);
    i_host.send(CMD_PIN_REL, 8'h00); reply(8'hF3);
    chk("pin0oe", 32'h0, {31'h0, ioOe[0]});
    i_host.send(CMD_HB, 8'h03); reply(8'hF4);
    repeat (5) @(posedge sysClk);
    #1 hbCnt = 0;
    repeat (64) @(posedge sysClk);
    chk("hbFast", 32'h1, 32'(hbCnt >= 8));
    i_host.send(CMD_HB, 8'h00); reply(8'hF4);
    repeat (5) @(posedge sysClk);
    hbCnt = 0;
    repeat (100) @(posedge sysClk);
    chk("hbOff", 32'h0, {31'h0, ioOe[PIN_HB]} | 32'(hbCnt));
    ahb(1'b1, {24'h0, REG_CTRL}, 32'h0000_0003, rd);
    ahb(1'b0, {24'h0, REG_CTRL}, 32'h0, rd); chk("ctrl", 32'h0000_0003, rd);
    ahb(1'b1, {24'h0, REG_CTRL}, 32'h0000_0000, rd);
    i_host.send(CMD_PIN_RD, 8'h20); reply(8'h01); reply(8'hF2);
    i_host.send(CMD_TWI_START, 8'h00); reply(8'hB0);
    chk("twiOd", 32'hC, {28'h0, ioOe[PIN_SDA:PIN_SCL], ioOut[PIN_SDA:PIN_SCL]});
    i_host.send(CMD_TWI_WRITE, 8'h55); reply(ERR_CODE);
    i_host.send(CMD_TWI_READ, 8'h01); reply(8'hFF); reply(8'hB2);
    i_host.send(CMD_TWI_TOG9, 8'h00); reply(8'hB4);
    i_host.send(CMD_TWI_STOP, 8'h00); reply(8'hB3);
    ahb(1'b0, {24'h0, REG_STAT}, 32'h0, rd); chk("stat", 32'h0000_0011, rd);
    i_host.set_dtr(1'b0);
    repeat (10) @(posedge sysClk);
    chk("oeHeld", 32'h0, {21'h0, ioOe & 11'h7FB});
    i_host.set_dtr(1'b1);
    banner();
    close_out();
  end
endmodule
